// ==== rtl/slp_latch_prog.sv ====
// Serial latch programming and power-down control of the synthesizer
`timescale 1ns/1ps
`include "slp_consts.svh"

module slp_latch_prog (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Serial link
    input  wire logic        serial_clk,
    input  wire logic        serial_data,
    input  wire logic        load_strobe,
    // Pins
    input  wire logic        chip_enable,
    input  wire logic        ref_div_out,
    // Control word fields
    output logic [1:0]       prescaler_sel,
    output logic             powerdown_gated_mode,
    output logic             powerdown_request,
    output logic [2:0]       pump_current_one,
    output logic [2:0]       pump_current_two,
    output logic [1:0]       rf_power_level,
    output logic             mute_until_lock,
    output logic             pump_gain_select,
    output logic             pump_three_state,
    output logic             detector_polarity,
    output logic [2:0]       output_mux_sel,
    output logic             counter_clear,
    output logic [1:0]       core_current,
    // Feedback divider word fields
    output logic             halved_feedback_sel,
    output logic             output_halve,
    output logic [12:0]      main_count,
    output logic [4:0]       swallow_count,
    // Reference divider word fields
    output logic [1:0]       band_clock_div,
    output logic             factory_test_bit,
    output logic             lock_precision,
    output logic [1:0]       antibacklash_width,
    output logic [13:0]      ref_divide,
    // Power and sequencing effects
    output logic             powered_down,
    output logic             counters_load,
    output logic             pump_hiz,
    output logic             lock_detect_clear,
    output logic             rf_out_hiz,
    output logic             ref_buffer_off,
    output logic             bias_settle_start,
    output logic             band_select_start
);

    // ----------------------------------------
    // Edge detection on link and reference pins
    // ----------------------------------------
    logic                      serial_clk_r;
    logic                      load_strobe_r;
    logic                      ref_div_out_r;
    logic                      sclk_rise;
    logic                      load_rise;
    logic                      ref_rise;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serial_clk_r  <= 1'b0;
            load_strobe_r <= 1'b0;
            ref_div_out_r <= 1'b0;
        end else begin
            serial_clk_r  <= serial_clk;
            load_strobe_r <= load_strobe;
            ref_div_out_r <= ref_div_out;
        end
    end

    assign sclk_rise = serial_clk & ~serial_clk_r;
    assign load_rise = load_strobe & ~load_strobe_r;
    assign ref_rise  = ref_div_out & ~ref_div_out_r;

    // ----------------------------------------
    // Input shift register
    // ----------------------------------------
    logic [`SLP_WORD_W-1:0]    shift_r;
    slp_pkg::slp_sel_t         sel;
    logic                      ld_ctrl;
    logic                      ld_ref;
    logic                      ld_fb;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_r <= `SLP_WORD_RST;
        end else if (sclk_rise) begin
            shift_r <= {shift_r[`SLP_WORD_W-2:0], serial_data};
        end
    end

    assign sel     = slp_pkg::slp_sel_t'(shift_r[`SLP_SEL_MSB:`SLP_SEL_LSB]);
    assign ld_ctrl = load_rise && (sel == slp_pkg::SLP_SEL_CONTROL);
    assign ld_ref  = load_rise && (sel == slp_pkg::SLP_SEL_REF);
    assign ld_fb   = load_rise && (sel == slp_pkg::SLP_SEL_FEEDBACK);

    // ----------------------------------------
    // Control word fields
    // ----------------------------------------
    // Test latch code stores nothing: factory use only
    // all control fields but the pump gain bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prescaler_sel        <= 2'h0;
            powerdown_gated_mode <= 1'b0;
            powerdown_request    <= 1'b0;
            pump_current_one     <= 3'h0;
            pump_current_two     <= 3'h0;
            rf_power_level       <= 2'h0;
            mute_until_lock      <= 1'b0;
            pump_three_state     <= 1'b0;
            detector_polarity    <= 1'b0;
            output_mux_sel       <= 3'h0;
            counter_clear        <= 1'b0;
            core_current         <= 2'h0;
        end else if (ld_ctrl) begin
            prescaler_sel        <= shift_r[`SLP_CW_PRESC_MSB:`SLP_CW_PRESC_LSB];
            powerdown_gated_mode <= shift_r[`SLP_CW_PD_MODE];
            powerdown_request    <= shift_r[`SLP_CW_PD_REQ];
            pump_current_one     <= shift_r[`SLP_CW_CP1_MSB:`SLP_CW_CP1_LSB];
            pump_current_two     <= shift_r[`SLP_CW_CP2_MSB:`SLP_CW_CP2_LSB];
            rf_power_level       <= shift_r[`SLP_CW_PWR_MSB:`SLP_CW_PWR_LSB];
            mute_until_lock      <= shift_r[`SLP_CW_MUTE];
            pump_three_state     <= shift_r[`SLP_CW_PUMP_HIZ];
            detector_polarity    <= shift_r[`SLP_CW_POLARITY];
            output_mux_sel       <= shift_r[`SLP_CW_MUX_MSB:`SLP_CW_MUX_LSB];
            counter_clear        <= shift_r[`SLP_CW_CLEAR];
            core_current         <= shift_r[`SLP_CW_CORE_MSB:`SLP_CW_CORE_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pump_gain_select <= 1'b0;
        end else if (ld_ctrl) begin
            pump_gain_select <= shift_r[`SLP_CW_GAIN];
        end else if (ld_fb) begin
            pump_gain_select <= shift_r[`SLP_NW_GAIN];
        end
    end

    // ----------------------------------------
    // Feedback and reference word fields
    // ----------------------------------------
    // reserved bits dropped
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            halved_feedback_sel <= 1'b0;
            output_halve        <= 1'b0;
            main_count          <= 13'h0;
            swallow_count       <= 5'h0;
        end else if (ld_fb) begin
            halved_feedback_sel <= shift_r[`SLP_NW_HALF_SEL];
            output_halve        <= shift_r[`SLP_NW_HALVE];
            main_count          <= shift_r[`SLP_NW_MAIN_MSB:`SLP_NW_MAIN_LSB];
            swallow_count       <= shift_r[`SLP_NW_SWAL_MSB:`SLP_NW_SWAL_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            band_clock_div     <= 2'h0;
            factory_test_bit   <= 1'b0;
            lock_precision     <= 1'b0;
            antibacklash_width <= 2'h0;
            ref_divide         <= 14'h0;
        end else if (ld_ref) begin
            band_clock_div     <= shift_r[`SLP_RW_BCLK_MSB:`SLP_RW_BCLK_LSB];
            factory_test_bit   <= shift_r[`SLP_RW_TEST];
            lock_precision     <= shift_r[`SLP_RW_LOCKP];
            antibacklash_width <= shift_r[`SLP_RW_ABW_MSB:`SLP_RW_ABW_LSB];
            ref_divide         <= shift_r[`SLP_RW_RDIV_MSB:`SLP_RW_RDIV_LSB];
        end
    end

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    slp_pkg::slp_state_t       state_r;
    slp_pkg::slp_state_t       state_nxt;
    logic [1:0]                ref_edges_r;
    logic [1:0]                ref_edges_nxt;
    logic                      pd_nxt;

    // mode decode on each control load
    always_comb begin
        state_nxt     = state_r;
        ref_edges_nxt = ref_edges_r;
        unique case (state_r)
            slp_pkg::SLP_ST_UNPOWERED,
            slp_pkg::SLP_ST_ACTIVE,
            slp_pkg::SLP_ST_DOWN: begin
                if (ld_ctrl) begin
                    if (!shift_r[`SLP_CW_PD_REQ]) begin
                        state_nxt = slp_pkg::SLP_ST_ACTIVE;
                    end else if (!shift_r[`SLP_CW_PD_MODE]) begin
                        state_nxt = slp_pkg::SLP_ST_DOWN;
                    end else if (state_r == slp_pkg::SLP_ST_ACTIVE) begin
                        state_nxt     = slp_pkg::SLP_ST_GATED;
                        ref_edges_nxt = 2'h0;
                    end
                end
            end
            slp_pkg::SLP_ST_GATED: begin
                if (ld_ctrl && !shift_r[`SLP_CW_PD_REQ]) begin
                    state_nxt = slp_pkg::SLP_ST_ACTIVE;
                end else if (ld_ctrl && !shift_r[`SLP_CW_PD_MODE]) begin
                    state_nxt = slp_pkg::SLP_ST_DOWN;
                end else if (ld_ctrl) begin
                    ref_edges_nxt = 2'h0;
                end else if (ref_rise) begin
                    ref_edges_nxt = ref_edges_r + 2'h1;
                    if (ref_edges_nxt == `SLP_GATED_EDGES) begin
                        state_nxt = slp_pkg::SLP_ST_DOWN;
                    end
                end
            end
            default: begin
                state_nxt = slp_pkg::SLP_ST_UNPOWERED;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r     <= slp_pkg::SLP_ST_UNPOWERED;
            ref_edges_r <= 2'h0;
        end else begin
            state_r     <= state_nxt;
            ref_edges_r <= ref_edges_nxt;
        end
    end

    // Gated wait keeps running until the second edge lands
    // chip enable overrides both bits
    assign pd_nxt = !chip_enable
                  || (state_nxt == slp_pkg::SLP_ST_UNPOWERED)
                  || (state_nxt == slp_pkg::SLP_ST_DOWN);

    // ----------------------------------------
    // Power-down effects
    // ----------------------------------------
    // counters held at load
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powered_down      <= 1'b1;
            counters_load     <= 1'b1;
            pump_hiz          <= 1'b1;
            rf_out_hiz        <= 1'b1;
            ref_buffer_off    <= 1'b1;
            lock_detect_clear <= 1'b1;
        end else begin
            powered_down      <= pd_nxt;
            counters_load     <= pd_nxt;
            pump_hiz          <= pd_nxt || (ld_ctrl ? shift_r[`SLP_CW_PUMP_HIZ]
                                                    : pump_three_state);
            rf_out_hiz        <= pd_nxt;
            ref_buffer_off    <= pd_nxt;
            lock_detect_clear <= pd_nxt;
        end
    end

    // ----------------------------------------
    // Sequencing pulses
    // ----------------------------------------
    // bias settling only on the step from unpowered to active
    // no band select on plain power-up
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bias_settle_start <= 1'b0;
            band_select_start <= 1'b0;
        end else begin
            bias_settle_start <= (state_r == slp_pkg::SLP_ST_UNPOWERED)
                              && (state_nxt == slp_pkg::SLP_ST_ACTIVE);
            band_select_start <= ld_fb;
        end
    end

endmodule : slp_latch_prog

// ==== rtl/slp_consts.svh ====
// Constants for the synthesizer latch programming block
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH

// ----------------------------------------
// Word shape
// ----------------------------------------
`define SLP_WORD_W          24
`define SLP_SEL_LSB         0
`define SLP_SEL_MSB         1

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define SLP_CW_PRESC_MSB    23
`define SLP_CW_PRESC_LSB    22
`define SLP_CW_PD_MODE      21
`define SLP_CW_PD_REQ       20
`define SLP_CW_CP2_MSB      19
`define SLP_CW_CP2_LSB      17
`define SLP_CW_CP1_MSB      16
`define SLP_CW_CP1_LSB      14
`define SLP_CW_PWR_MSB      13
`define SLP_CW_PWR_LSB      12
`define SLP_CW_MUTE         11
`define SLP_CW_GAIN         10
`define SLP_CW_PUMP_HIZ     9
`define SLP_CW_POLARITY     8
`define SLP_CW_MUX_MSB      7
`define SLP_CW_MUX_LSB      5
`define SLP_CW_CLEAR        4
`define SLP_CW_CORE_MSB     3
`define SLP_CW_CORE_LSB     2

// ----------------------------------------
// Feedback divider word fields
// ----------------------------------------
`define SLP_NW_HALF_SEL     23
`define SLP_NW_HALVE        22
`define SLP_NW_GAIN         21
`define SLP_NW_MAIN_MSB     20
`define SLP_NW_MAIN_LSB     8
`define SLP_NW_SWAL_MSB     6
`define SLP_NW_SWAL_LSB     2

// ----------------------------------------
// Reference divider word fields
// ----------------------------------------
`define SLP_RW_BCLK_MSB     21
`define SLP_RW_BCLK_LSB     20
`define SLP_RW_TEST         19
`define SLP_RW_LOCKP        18
`define SLP_RW_ABW_MSB      17
`define SLP_RW_ABW_LSB      16
`define SLP_RW_RDIV_MSB     15
`define SLP_RW_RDIV_LSB     2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define SLP_WORD_RST        24'h00_0000
`define SLP_GATED_EDGES     2'h2

`endif

// ==== rtl/slp_pkg.sv ====
// Types for the synthesizer latch programming block
package slp_pkg;

    // ----------------------------------------
    // Power state, one-hot
    // ----------------------------------------
    typedef enum logic [3:0] {
        SLP_ST_UNPOWERED = 4'h1,
        SLP_ST_ACTIVE    = 4'h2,
        SLP_ST_GATED     = 4'h4,
        SLP_ST_DOWN      = 4'h8
    } slp_state_t;

    // ----------------------------------------
    // Latch select codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        SLP_SEL_CONTROL  = 2'h0,
        SLP_SEL_REF      = 2'h1,
        SLP_SEL_FEEDBACK = 2'h2,
        SLP_SEL_TEST     = 2'h3
    } slp_sel_t;

endpackage : slp_pkg

// ==== test/slp_latch_prog_asserts.sv ====
// Port-level checks for the latch programming block
`timescale 1ns/1ps
module slp_latch_prog_asserts (
    // Clock, reset, serial link and pins
    input wire logic clk, sys_rst, serial_clk, serial_data, load_strobe, chip_enable,
    // Observed outputs
    input wire logic powerdown_gated_mode, powerdown_request, pump_gain_select,
    input wire logic pump_three_state, powered_down, counters_load, pump_hiz,
    input wire logic lock_detect_clear, rf_out_hiz, ref_buffer_off, band_select_start
);
    // ----
    // Shadow of the input register
    // ----
    logic [23:0] shift_r;
    logic [23:0] word_r;
    logic        sclk_r;
    logic        strobe_r;
    logic        load_rise;
    logic        ctl_ld;
    logic        fb_ld;

    assign load_rise = load_strobe && !strobe_r;
    assign ctl_ld    = load_rise && shift_r[1:0] == 2'h0;
    assign fb_ld     = load_rise && shift_r[1:0] == 2'h2;

    always_ff @(posedge clk) begin
        sclk_r   <= sys_rst ? 1'b0 : serial_clk;
        strobe_r <= sys_rst ? 1'b0 : load_strobe;
    end
    // Load sees the word before any same-edge shift
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_r <= 24'h00_0000;
        end else if (serial_clk && !sclk_r) begin
            shift_r <= {shift_r[22:0], serial_data};
        end
    end
    always_ff @(posedge clk) begin
        if (load_rise) begin
            word_r <= shift_r;
        end
    end

    // ----
    // Assertions
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_CE_LOW: assert property (!chip_enable |=> powered_down)
        else $error("chip enable low left device up");
    AST_PD_GROUP: assert property (powered_down == counters_load
        && powered_down == lock_detect_clear && powered_down == rf_out_hiz
        && powered_down == ref_buffer_off) else $error("power-down effects disagree");
    AST_PUMP_HIZ: assert property (pump_hiz == (powered_down || pump_three_state))
        else $error("pump three-state wrong");
    AST_ASYNC_PD: assert property (ctl_ld && shift_r[21:20] == 2'h1 |=> powered_down)
        else $error("immediate power-down missed");
    AST_GATED_WAIT: assert property (ctl_ld && shift_r[21:20] == 2'h3
        && chip_enable && !powered_down |=> !powered_down) else $error("gated entry too early");
    AST_RESUME: assert property (ctl_ld && !shift_r[20] && chip_enable |=> !powered_down)
        else $error("control load did not power up");
    AST_PD_BITS: assert property (ctl_ld
        |=> {powerdown_gated_mode, powerdown_request} == word_r[21:20])
        else $error("power-down bits wrong");
    AST_GAIN_CTRL: assert property (ctl_ld |=> pump_gain_select == word_r[10])
        else $error("gain not taken from control word");
    AST_GAIN_FB: assert property (fb_ld |=> pump_gain_select == word_r[21])
        else $error("gain not taken from feedback word");
    AST_BAND: assert property (fb_ld |=> band_select_start ##1 !band_select_start)
        else $error("band select pulse wrong");
endmodule : slp_latch_prog_asserts

// ==== test/slp_host_model.sv ====
// Host model driving the three-wire serial link
`timescale 1ns/1ps
module slp_host_model (
    // Clock
    input  wire logic clk,
    // Serial link
    output logic      serial_clk,
    output logic      serial_data,
    output logic      load_strobe
);
    initial begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    task automatic send_word(input logic [23:0] word);
        logic [23:0] w;
        w = word;
        if (w[1:0] == 2'h1) begin
            w[23:22] = 2'h0;
        end
        if (w[1:0] == 2'h2) begin
            w[7] = 1'b0;
        end
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk);
            serial_clk  = 1'b0;
            serial_data = w[i];
            @(negedge clk);
            serial_clk = 1'b1;
        end
        @(negedge clk);
        serial_clk  = 1'b0;
        // Released data line must not look held
        serial_data = ~w[0];
        @(negedge clk);
        load_strobe = 1'b1;
        repeat (2) @(negedge clk);
        load_strobe = 1'b0;
        @(negedge clk);
    endtask : send_word
endmodule : slp_host_model

// ==== test/tb_top.sv ====
// Self-checking bench for the latch programming block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    // ----
    // Signals
    // ----
    logic        clk, sys_rst, serial_clk, serial_data, load_strobe, chip_enable, ref_div_out;
    logic        powerdown_gated_mode, powerdown_request, mute_until_lock, pump_gain_select;
    logic        pump_three_state, detector_polarity, counter_clear, halved_feedback_sel;
    logic        output_halve, factory_test_bit, lock_precision, powered_down, counters_load;
    logic        pump_hiz, lock_detect_clear, rf_out_hiz, ref_buffer_off, bias_settle_start;
    logic        band_select_start;
    logic [1:0]  prescaler_sel, rf_power_level, core_current, band_clock_div, antibacklash_width;
    logic [2:0]  pump_current_one, pump_current_two, output_mux_sel;
    logic [4:0]  swallow_count;
    logic [12:0] main_count;
    logic [13:0] ref_divide;
    logic [61:0] snap;
    int          error_cnt, tests_run, band_n, bias_n, n0, b0;
    // Words with every field distinct; reserved bits zero
    localparam logic [23:0] REF_W  = {4'h2, 2'h1, 2'h1, 14'h1235, 2'h1};
    localparam logic [23:0] CTRL_W = {2'h2, 2'h0, 3'h5, 3'h3, 2'h1, 4'hD, 3'h6, 1'h1, 2'h2, 2'h0};
    localparam logic [23:0] FB_W   = {3'h4, 13'h1A5C, 1'h0, 5'h15, 2'h2};

    slp_host_model host (.*);
    slp_latch_prog DUT (.*);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Pulse counters, so a one-cycle strobe is never missed
    always @(posedge clk) begin
        band_n += int'(band_select_start === 1'b1);
        bias_n += int'(bias_settle_start === 1'b1);
    end

    function automatic logic [23:0] ctl(input logic [1:0] pd);
        return {CTRL_W[23:22], pd, CTRL_W[19:0]};
    endfunction : ctl
    function automatic logic [61:0] fields();
        return {prescaler_sel, powerdown_gated_mode, powerdown_request, pump_current_two,
            pump_current_one, rf_power_level, mute_until_lock, pump_gain_select,
            pump_three_state, detector_polarity, output_mux_sel, counter_clear, core_current,
            halved_feedback_sel, output_halve, main_count, swallow_count, band_clock_div,
            factory_test_bit, lock_precision, antibacklash_width, ref_divide};
    endfunction : fields

    // ----
    // Scenarios
    // ----
    task automatic t_power_up();
        `CHK("down_at_reset", 1'b1, powered_down)
        b0 = bias_n;
        host.send_word(REF_W);
        snap = fields();
        `CHK("ref_fields", REF_W[21:2], snap[19:0])
        host.send_word(ctl(2'h0));
        snap = fields();
        `CHK("ctrl_fields", CTRL_W[23:2], snap[61:40])
        `CHK("bias_pulse", b0 + 1, bias_n)
        `CHK("powered_up", 1'b0, powered_down)
        // Settling wait scaled down; only the order matters here
        repeat (40) @(negedge clk);
        n0 = band_n;
        host.send_word(FB_W);
        snap = fields();
        `CHK("fb_fields", ({FB_W[23:22], FB_W[20:8], FB_W[6:2]}), snap[39:20])
        `CHK("fb_gain", FB_W[21], pump_gain_select)
        `CHK("band_pulse", n0 + 1, band_n)
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_async();
        logic [4:0] grp;
        n0 = band_n;
        b0 = bias_n;
        host.send_word(ctl(2'h1));
        grp = {counters_load, lock_detect_clear, rf_out_hiz, ref_buffer_off, pump_hiz};
        `CHK("async_down", 1'b1, powered_down)
        `CHK("down_group", 5'h1F, grp)
        `CHK("ctrl_gain", 1'b1, pump_gain_select)
        host.send_word({REF_W[23:16], 14'h0ABC, 2'h1});
        `CHK("load_while_down", 14'h0ABC, ref_divide)
        // Gated request is refused while already down
        host.send_word(ctl(2'h3));
        `CHK("gated_while_down", 1'b1, powered_down)
        host.send_word(ctl(2'h0));
        `CHK("resume", 1'b0, powered_down)
        `CHK("band_kept", n0, band_n)
        `CHK("main_kept", FB_W[20:8], main_count)
        `CHK("no_bias", b0, bias_n)
        $display("test async done");
    endtask : t_async

    task automatic t_gated();
        host.send_word(ctl(2'h3));
        `CHK("gated_wait", 1'b0, powered_down)
        ref_div_out = 1'b1;
        repeat (2) @(negedge clk);
        ref_div_out = 1'b0;
        // Fresh gated load restarts the edge count
        host.send_word(ctl(2'h3));
        `CHK("gated_restart", 1'b0, powered_down)
        for (int i = 1; i <= 2; i++) begin
            ref_div_out = 1'b1;
            @(negedge clk);
            `CHK("gated_edge", (i == 2), powered_down)
            ref_div_out = 1'b0;
            repeat (2) @(negedge clk);
        end
        // Pump three-state field shows on the pump while powered up
        host.send_word(ctl(2'h0) | 24'h00_0200);
        `CHK("gated_resume", 1'b0, powered_down)
        `CHK("pump_field_hiz", 1'b1, pump_hiz)
        $display("test gated done");
    endtask : t_gated

    task automatic t_ce();
        chip_enable = 1'b0;
        @(negedge clk);
        `CHK("ce_down", 1'b1, powered_down)
        host.send_word(ctl(2'h0));
        `CHK("ce_overrides", 1'b1, powered_down)
        chip_enable = 1'b1;
        @(negedge clk);
        `CHK("ce_up", 1'b0, powered_down)
        `CHK("ce_pump", 1'b0, pump_hiz)
        $display("test chip_enable done");
    endtask : t_ce

    task automatic t_test_latch();
        snap = fields();
        n0 = band_n;
        host.send_word(24'hFF_FFFF);
        `CHK("test_latch_fields", snap, fields())
        `CHK("test_latch_band", n0, band_n)
        $display("test test_latch done");
    endtask : t_test_latch

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    initial begin
        sys_rst     = 1'b1;
        chip_enable = 1'b1;
        ref_div_out = 1'b0;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        t_power_up();
        t_async();
        t_gated();
        t_ce();
        t_test_latch();
        print_verdict();
    end
    // Hang guard
    initial begin
        #250000;
        error_cnt++;
        print_verdict();
    end
endmodule : tb_top

bind slp_latch_prog slp_latch_prog_asserts chk (.*);
